// ===== rtl/bpc_consts.svh
`ifndef BPC_CONSTS_SVH
`define BPC_CONSTS_SVH
// Port organisation
`define BPC_PORTS 5
`define BPC_LINES 8
`define BPC_ALL_LINES 40
// Register index window (byte address is four times the index)
`define BPC_IDX_LSB 2
`define BPC_IDX_MSB 9
`define BPC_HSIZE_WORD 3'h2
// Data register indices, ports A to E
`define BPC_IDX_DATA_A 8'hC0
`define BPC_IDX_DATA_B 8'hC1
`define BPC_IDX_DATA_C 8'hC2
`define BPC_IDX_DATA_D 8'hC3
`define BPC_IDX_DATA_E 8'hFC
// Direction register indices, ports A to E
`define BPC_IDX_DIR_A 8'hC4
`define BPC_IDX_DIR_B 8'hC5
`define BPC_IDX_DIR_C 8'hC6
`define BPC_IDX_DIR_D 8'hC7
`define BPC_IDX_DIR_E 8'hFD
// Option register indices, ports A to E
`define BPC_IDX_OPT_A 8'hCC
`define BPC_IDX_OPT_B 8'hCD
`define BPC_IDX_OPT_C 8'hCE
`define BPC_IDX_OPT_D 8'hCF
`define BPC_IDX_OPT_E 8'hFE
// Alternate-function control and interrupt trigger select
`define BPC_IDX_CTRL 8'hE0
`define BPC_IDX_TRIG 8'hE1
`define BPC_CTRL_PWM_EN 0
`define BPC_CTRL_OVF_EN 1
`define BPC_CTRL_RLD_LO 2
`define BPC_CTRL_RLD_HI 3
`define BPC_CTRL_W 4
`define BPC_TRIG_W 10
// Reset values
`define BPC_RST_PORT 8'h00
`define BPC_RST_CTRL 4'h0
`define BPC_RST_TRIG 10'h000
// Line availability, port E in the top byte
`define BPC_IMPL_MASK 40'h1F_FF_E0_F9_FF
`define BPC_ANALOG_MASK 40'h00_FF_E0_F9_F0
// Lines with alternate functions, as flat line numbers
`define BPC_LINE_OVF 2
`define BPC_LINE_PWM 3
`define BPC_LINE_CAP1 4
`define BPC_LINE_CAP2 5
`define BPC_LINE_SCLK 25
`define BPC_LINE_SIN 26
`define BPC_LINE_SOUT 27
`define BPC_LINE_RXD 28
`define BPC_LINE_TXD 29
`endif

// ===== rtl/bpc_io_port.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_consts.svh"
// Function
// - dir0 opt0 data0: input with pull-up
// - dir0 opt0 data1: floating input
// - dir0 opt1 data0: pull-up input with interrupt
// - dir0 opt1 data1: analog where available
// - dir1 opt0: open-drain output
// - dir1 opt1: push-pull output from latch
// - input-mode data read returns pin level
// - per-port trigger: falling, rising, low level
// - analog lines feed converter multiplexer
// - timer enables low: ordinary I/O line
// - capture lines readable, capture when enabled and line is an input
// - serial out only when open-drain
// - UART receive line always readable
// - UART transmit shows latch when idle
// - option registers per port, bit per line
// - direction registers per port, bit per line
// - reset clears all port registers
module bpc_io_port #(
  parameter logic [39:0] IMPL_MASK = `BPC_IMPL_MASK,
  parameter logic [39:0] ANALOG_MASK = `BPC_ANALOG_MASK
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [39:0] pad_in,
  output logic [39:0] pad_out,
  output logic [39:0] pad_oe,
  output logic [39:0] pad_pull_up_en,
  output logic [39:0] analog_sel,
  output logic [4:0] port_irq,
  input wire logic pulse_width_output,
  input wire logic overflow_output,
  input wire logic spi_serial_out,
  input wire logic uart_transmit_data,
  input wire logic uart_transmit_active,
  output logic capture_input_one,
  output logic capture_input_two,
  output logic spi_serial_in,
  output logic spi_serial_clock,
  output logic uart_receive_line
);
  localparam int NP = `BPC_PORTS;
  localparam int NL = `BPC_ALL_LINES;
  // Register index tables, port A first
  localparam logic [7:0] DATA_IDX [NP] = '{`BPC_IDX_DATA_A, `BPC_IDX_DATA_B,
    `BPC_IDX_DATA_C, `BPC_IDX_DATA_D, `BPC_IDX_DATA_E};
  localparam logic [7:0] DIR_IDX [NP] = '{`BPC_IDX_DIR_A, `BPC_IDX_DIR_B,
    `BPC_IDX_DIR_C, `BPC_IDX_DIR_D, `BPC_IDX_DIR_E};
  localparam logic [7:0] OPT_IDX [NP] = '{`BPC_IDX_OPT_A, `BPC_IDX_OPT_B,
    `BPC_IDX_OPT_C, `BPC_IDX_OPT_D, `BPC_IDX_OPT_E};

  bpc_pkg::bpc_byte_t pin_data_latch [NP]; // Data latches
  bpc_pkg::bpc_byte_t port_direction [NP]; // Direction registers
  bpc_pkg::bpc_byte_t port_option [NP]; // Option registers
  bpc_pkg::bpc_byte_t next_data [NP];
  bpc_pkg::bpc_byte_t next_dir [NP];
  bpc_pkg::bpc_byte_t next_opt [NP];
  logic [`BPC_CTRL_W-1:0] alt_ctrl; // Timer enables and reload selects
  logic [`BPC_CTRL_W-1:0] next_ctrl;
  logic [`BPC_TRIG_W-1:0] trig_sel; // Two bits of trigger per port
  logic [`BPC_TRIG_W-1:0] next_trig;
  logic wr_pend; // Write data phase under way
  logic [7:0] wr_idx; // Index latched in the address phase
  logic addr_take; // Address phase accepted this edge
  logic [7:0] rd_idx; // Index of the current address phase
  logic [31:0] rd_val; // Read value, forwarded past a pending write
  logic [NL-1:0] pin_level; // Synchronised pin levels
  logic [NL-1:0] pin_prev; // Previous levels, for edge detection
  logic [NL-1:0] dir_flat;
  logic [NL-1:0] opt_flat;
  logic [NL-1:0] dat_flat;
  logic [NL-1:0] cfg_pull;
  logic [NL-1:0] cfg_irq;
  logic [NL-1:0] cfg_analog;
  logic [NL-1:0] is_od; // Line is an open-drain output
  logic [NL-1:0] is_pp; // Line is a push-pull output
  logic [NL-1:0] drive_val; // Value a line drives when it is an output
  logic [NP-1:0] next_irq;
  logic pwm_en;
  logic ovf_en;

  assign pwm_en = alt_ctrl[`BPC_CTRL_PWM_EN];
  assign ovf_en = alt_ctrl[`BPC_CTRL_OVF_EN];
  // Only whole-word transfers reach the registers; narrower ones are ignored
  assign addr_take = hsel & hready & htrans[1] & (hsize == `BPC_HSIZE_WORD);
  assign rd_idx = haddr[`BPC_IDX_MSB:`BPC_IDX_LSB];

  // Pad synchroniser
  bpc_sync #(
    .W(NL)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(pad_in),
    .filt_out(pin_level)
  );

  // Per-line mode decode
  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_line
      bpc_pkg::bpc_mode_e line_mode;
      assign dir_flat[gi] = port_direction[gi / 8][gi % 8];
      assign opt_flat[gi] = port_option[gi / 8][gi % 8];
      assign dat_flat[gi] = pin_data_latch[gi / 8][gi % 8];
      bpc_line_cfg #(
        .ANALOG_OK(ANALOG_MASK[gi])
      ) u_cfg (
        .dir_bit(dir_flat[gi]),
        .opt_bit(opt_flat[gi]),
        .dat_bit(dat_flat[gi]),
        .mode(line_mode),
        .pull_up(cfg_pull[gi]),
        .irq_en(cfg_irq[gi]),
        .analog_req(cfg_analog[gi])
      );
      assign is_od[gi] = (line_mode == bpc_pkg::bpc_out_od);
      assign is_pp[gi] = (line_mode == bpc_pkg::bpc_out_pp);
    end
  endgenerate

  // Address phase capture; a write is applied in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      // Upper address bits set means unmapped, so the write is dropped
      wr_pend <= addr_take & hwrite & (haddr[31:10] == 22'h000000);
      wr_idx <= rd_idx;
    end
  end

  // Next register contents: hold unless the data phase writes them
  always_comb begin
    next_ctrl = alt_ctrl;
    next_trig = trig_sel;
    for (int p = 0; p < NP; p++) begin
      next_data[p] = pin_data_latch[p];
      next_dir[p] = port_direction[p];
      next_opt[p] = port_option[p];
      // Unimplemented lines stay zero in every register
      if (wr_pend && wr_idx == DATA_IDX[p]) begin
        next_data[p] = hwdata[7:0] & IMPL_MASK[p*8 +: 8];
      end
      if (wr_pend && wr_idx == DIR_IDX[p]) begin
        next_dir[p] = hwdata[7:0] & IMPL_MASK[p*8 +: 8];
      end
      if (wr_pend && wr_idx == OPT_IDX[p]) begin
        next_opt[p] = hwdata[7:0] & IMPL_MASK[p*8 +: 8];
      end
    end
    if (wr_pend && wr_idx == `BPC_IDX_CTRL) begin
      next_ctrl = hwdata[`BPC_CTRL_W-1:0];
    end
    if (wr_pend && wr_idx == `BPC_IDX_TRIG) begin
      next_trig = hwdata[`BPC_TRIG_W-1:0];
    end
  end

  // Port register storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < NP; p++) begin
        pin_data_latch[p] <= `BPC_RST_PORT;
        port_direction[p] <= `BPC_RST_PORT;
        port_option[p] <= `BPC_RST_PORT;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        pin_data_latch[p] <= next_data[p];
        port_direction[p] <= next_dir[p];
        port_option[p] <= next_opt[p];
      end
    end
  end

  // Alternate-function and trigger registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alt_ctrl <= `BPC_RST_CTRL;
      trig_sel <= `BPC_RST_TRIG;
    end else begin
      alt_ctrl <= next_ctrl;
      trig_sel <= next_trig;
    end
  end

  // Read mux; uses next values so a read right behind a write sees it
  always_comb begin
    rd_val = 32'h00000000;
    for (int p = 0; p < NP; p++) begin
      if (rd_idx == DATA_IDX[p]) begin
        // Inputs show the pin, outputs the latch
        rd_val = {24'h000000, ((next_dir[p] & next_data[p]) |
          (~next_dir[p] & pin_level[p*8 +: 8])) & IMPL_MASK[p*8 +: 8]};
      end
      if (rd_idx == DIR_IDX[p]) begin
        rd_val = {24'h000000, next_dir[p]};
      end
      if (rd_idx == OPT_IDX[p]) begin
        rd_val = {24'h000000, next_opt[p]};
      end
    end
    if (rd_idx == `BPC_IDX_CTRL) begin
      rd_val = {28'h0000000, next_ctrl};
    end
    if (rd_idx == `BPC_IDX_TRIG) begin
      rd_val = {22'h000000, next_trig};
    end
    // Unmapped addresses read zero
    if (haddr[31:10] != 22'h000000) begin
      rd_val = 32'h00000000;
    end
  end

  // Bus answer; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_take && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // Output value per line, with alternate functions overlaid
  always_comb begin
    drive_val = dat_flat;
    // With enables low the timer lines keep their latch value
    if (pwm_en && dir_flat[`BPC_LINE_PWM]) begin
      drive_val[`BPC_LINE_PWM] = pulse_width_output;
    end
    if (ovf_en && dir_flat[`BPC_LINE_OVF]) begin
      drive_val[`BPC_LINE_OVF] = overflow_output;
    end
    // Serial data only leaves through the open-drain mode
    if (is_od[`BPC_LINE_SOUT]) begin
      drive_val[`BPC_LINE_SOUT] = spi_serial_out;
    end
    if (uart_transmit_active) begin
      drive_val[`BPC_LINE_TXD] = uart_transmit_data;
    end
  end

  // Pad drivers; open-drain only ever pulls low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= '0;
      pad_oe <= '0;
    end else begin
      pad_out <= is_pp & drive_val;
      pad_oe <= is_pp | (is_od & ~drive_val);
    end
  end

  // Input conditioning; updates one edge after the latch changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_pull_up_en <= '0;
      analog_sel <= '0;
    end else begin
      pad_pull_up_en <= cfg_pull & IMPL_MASK;
      // Several set bits short pins together; software must avoid it
      analog_sel <= cfg_analog;
    end
  end

  // Interrupt request per port from its enabled lines
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      case (bpc_pkg::bpc_trig_e'(trig_sel[2*p +: 2]))
        bpc_pkg::bpc_trig_fall: begin
          next_irq[p] = |(cfg_irq[p*8 +: 8] & pin_prev[p*8 +: 8] & ~pin_level[p*8 +: 8]);
        end
        bpc_pkg::bpc_trig_rise: begin
          next_irq[p] = |(cfg_irq[p*8 +: 8] & ~pin_prev[p*8 +: 8] & pin_level[p*8 +: 8]);
        end
        bpc_pkg::bpc_trig_low: begin
          next_irq[p] = |(cfg_irq[p*8 +: 8] & ~pin_level[p*8 +: 8]);
        end
        default: begin
          next_irq[p] = 1'b0;
        end
      endcase
    end
  end

  // Edge history and interrupt outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev <= '0;
      port_irq <= '0;
    end else begin
      pin_prev <= pin_level;
      port_irq <= next_irq & {NP{1'b1}};
    end
  end

  // Peripheral input taps; the port read path is independent of these
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_input_one <= 1'b0;
      capture_input_two <= 1'b0;
      spi_serial_in <= 1'b0;
      spi_serial_clock <= 1'b0;
      uart_receive_line <= 1'b0;
    end else begin
      // Capture only sees the pin while selected and the line is an input
      capture_input_one <= alt_ctrl[`BPC_CTRL_RLD_LO] & ~dir_flat[`BPC_LINE_CAP1] &
        pin_level[`BPC_LINE_CAP1];
      capture_input_two <= alt_ctrl[`BPC_CTRL_RLD_HI] & ~dir_flat[`BPC_LINE_CAP2] &
        pin_level[`BPC_LINE_CAP2];
      spi_serial_in <= pin_level[`BPC_LINE_SIN];
      spi_serial_clock <= pin_level[`BPC_LINE_SCLK];
      uart_receive_line <= pin_level[`BPC_LINE_RXD];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bpc_line_cfg.sv
`timescale 1ns/1ps
`default_nettype none
// Decodes one line's direction, option and data bits into its mode
module bpc_line_cfg #(
  parameter bit ANALOG_OK = 1'b1
) (
  input wire logic dir_bit,
  input wire logic opt_bit,
  input wire logic dat_bit,
  output var bpc_pkg::bpc_mode_e mode,
  output logic pull_up,
  output logic irq_en,
  output logic analog_req
);
  // Mode table
  always_comb begin
    pull_up = 1'b0;
    irq_en = 1'b0;
    analog_req = 1'b0;
    case ({dir_bit, opt_bit, dat_bit})
      3'h0: begin
        mode = bpc_pkg::bpc_in_pull;
        pull_up = 1'b1;
      end
      3'h1: begin
        mode = bpc_pkg::bpc_in_hiz;
      end
      3'h2: begin
        mode = bpc_pkg::bpc_in_irq;
        pull_up = 1'b1;
        irq_en = 1'b1;
      end
      3'h3: begin
        // Lines without an analog path fall back to a floating input
        mode = bpc_pkg::bpc_in_analog;
        analog_req = ANALOG_OK;
      end
      3'h4, 3'h5: begin
        mode = bpc_pkg::bpc_out_od;
      end
      3'h6, 3'h7: begin
        mode = bpc_pkg::bpc_out_pp;
      end
      default: begin
        mode = bpc_pkg::bpc_in_pull;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/bpc_pkg.sv
package bpc_pkg;
  // One byte of a port register
  typedef logic [7:0] bpc_byte_t;
  // Per-line configuration decoded from direction, option and data
  typedef enum logic [5:0] {
    bpc_in_pull = 6'h01,
    bpc_in_hiz = 6'h02,
    bpc_in_irq = 6'h04,
    bpc_in_analog = 6'h08,
    bpc_out_od = 6'h10,
    bpc_out_pp = 6'h20
  } bpc_mode_e;
  // Per-port interrupt trigger
  typedef enum logic [1:0] {
    bpc_trig_fall = 2'h0,
    bpc_trig_rise = 2'h1,
    bpc_trig_low = 2'h2
  } bpc_trig_e;
endpackage

// ===== rtl/bpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; a change is accepted once stages two and three agree
module bpc_sync #(
  parameter int W = 40
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] filt_out
);
  logic [W-1:0] stage1; // Metastability catcher, read only by stage2
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // Shift chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Agreement filter; a one-cycle glitch never reaches the port logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_out <= '0;
    end else begin
      filt_out <= (stage2 & stage3) | (filt_out & (stage2 ^ stage3));
    end
  end
endmodule
`default_nettype wire

// ===== testbench/bpc_io_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Pin and bus side watch on the port block
module bpc_io_port_checker #(
  parameter logic [39:0] IMPL_MASK = 40'h0,
  parameter logic [39:0] ANALOG_MASK = 40'h0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [39:0] pad_in,
  input wire logic [39:0] pad_oe,
  input wire logic [39:0] pad_pull_up_en,
  input wire logic [39:0] analog_sel,
  input wire logic spi_serial_in,
  input wire logic uart_receive_line
);
  // Lines whose enable follows a register only, never a peripheral
  // Timer lines A2 and A3, serial out D3 and transmit line D5 are left out
  localparam logic [39:0] REG_ONLY = 40'hFF_D7_FF_FF_F3;
  logic [3:0] up_cnt; // Cycles since reset; the synchroniser starts from 0
  logic [2:0] wr_pipe; // Accepted writes, aged one cycle per stage
  // Saturating age counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_cnt <= 4'h0;
    end else if (up_cnt != 4'hF) begin
      up_cnt <= up_cnt + 4'h1;
    end
  end
  // Write history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pipe <= 3'h0;
    end else begin
      wr_pipe <= {wr_pipe[1:0], hsel && hready && htrans[1] && hwrite};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Pin held still long enough to cross the synchroniser
  sequence steady(s);
    (up_cnt == 4'hF && $stable(s)) [*6];
  endsequence
  reset_state_a: assert property ($rose(hresetn) |=>
    pad_pull_up_en == IMPL_MASK && pad_oe == 40'h0) else $error("bad state after reset");
  pull_oe_excl_a: assert property ((pad_pull_up_en & pad_oe) == 40'h0)
    else $error("pull-up on a driven line");
  pull_analog_excl_a: assert property ((pad_pull_up_en & analog_sel) == 40'h0)
    else $error("pull-up on an analog line");
  analog_mask_a: assert property ((analog_sel & ~ANALOG_MASK) == 40'h0)
    else $error("analog path on a line without one");
  impl_mask_a: assert property (((pad_oe | pad_pull_up_en) & ~IMPL_MASK) == 40'h0)
    else $error("missing line enabled");
  cfg_after_write_a: assert property ($changed({pad_oe & REG_ONLY, analog_sel})
    |-> wr_pipe[2]) else $error("line set-up changed without a write");
  uart_rx_tap_a: assert property (steady(pad_in[28]) |-> uart_receive_line == pad_in[28])
    else $error("receive line does not follow pin");
  spi_in_tap_a: assert property (steady(pad_in[26]) |-> spi_serial_in == pad_in[26])
    else $error("serial input does not follow pin");
endmodule
bind bpc_io_port bpc_io_port_checker #(.IMPL_MASK(IMPL_MASK), .ANALOG_MASK(ANALOG_MASK)) chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .pad_in(pad_in), .pad_oe(pad_oe), .pad_pull_up_en(pad_pull_up_en),
  .analog_sel(analog_sel), .spi_serial_in(spi_serial_in), .uart_receive_line(uart_receive_line)
);
`default_nettype wire

// ===== testbench/bpc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board at the pins: bench sources, pull-ups, else a wandering level
module bpc_pin_model (
  input wire logic hclk,
  input wire logic [39:0] pad_out,
  input wire logic [39:0] pad_oe,
  input wire logic [39:0] pad_pull_up_en,
  input wire logic [39:0] ext_en,
  input wire logic [39:0] ext_val,
  output logic [39:0] pad_in
);
  logic flt; // Floating level, flips every cycle so stale data never looks valid
  // Flip once a cycle
  always @(posedge hclk) begin
    flt <= (flt === 1'b1) ? 1'b0 : 1'b1;
  end
  // Device drive wins, then the bench source, then the pull-up
  always_comb begin
    pad_in = pad_oe & pad_out;
    pad_in |= ~pad_oe & ext_en & ext_val;
    pad_in |= ~pad_oe & ~ext_en & pad_pull_up_en;
    pad_in |= ~pad_oe & ~ext_en & ~pad_pull_up_en & {40{flt}};
  end
endmodule
`default_nettype wire

// ===== testbench/tb_bytewise_io_port_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpc_consts.svh"
// Register-level bench for the port block
module tb_bytewise_io_port_config;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [39:0] pad_in, pad_out, pad_oe, pull_en, ana_sel, ext_en, ext_val;
  logic [4:0] port_irq;
  logic pwm_o, ovf_o, sout, txd, tx_act, cap1, cap2, sin, sclk, rxd;
  int miscompares;
  int n_tests;
  int a;
  int b;
  // Direction then option registers, ports A to E
  logic [7:0] regs [10] = '{`BPC_IDX_DIR_A, `BPC_IDX_DIR_B, `BPC_IDX_DIR_C, `BPC_IDX_DIR_D,
    `BPC_IDX_DIR_E, `BPC_IDX_OPT_A, `BPC_IDX_OPT_B, `BPC_IDX_OPT_C, `BPC_IDX_OPT_D,
    `BPC_IDX_OPT_E};
  logic [3:0] caps [3] = '{4'h4, 4'hC, 4'h0}; // Capture enable steps
  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  bpc_io_port uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up_en(pull_en), .analog_sel(ana_sel), .port_irq(port_irq),
    .pulse_width_output(pwm_o), .overflow_output(ovf_o), .spi_serial_out(sout),
    .uart_transmit_data(txd), .uart_transmit_active(tx_act), .capture_input_one(cap1),
    .capture_input_two(cap2), .spi_serial_in(sin), .spi_serial_clock(sclk),
    .uart_receive_line(rxd)
  );
  bpc_pin_model pins (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up_en(pull_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  // Compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single bus transfer; read data lands in rv
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask
  // Data, option, direction of one port; data first so no line glitches to a stale mode
  task automatic cfg(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] o,
                     input logic [7:0] r);
    xfer(1'b1, idx, 32'(d));
    xfer(1'b1, idx + 8'hC, 32'(o));
    xfer(1'b1, idx + 8'h4, 32'(r));
  endtask
  // Let outputs land; flop outputs are read at the next edge, before it updates them
  task automatic settle(input int n);
    repeat (n + 1) @(posedge hclk);
  endtask
  // Cycles with the port A request high over a window
  task automatic cnt_irq(output int c);
    c = 0;
    repeat (12) begin
      @(posedge hclk);
      c += (port_irq[0] === 1'b1) ? 1 : 0;
    end
  endtask
  // Verdict
  task automatic test_done;
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    test_done;
  end
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, ext_en, ext_val} = '0;
    {pwm_o, ovf_o, sout, txd, tx_act} = 5'h0;
    hsize = `BPC_HSIZE_WORD;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    settle(2);
    chk(pull_en, `BPC_IMPL_MASK);
    // Reset value, write, read back masked to present lines, restore
    for (int i = 0; i < 10; i++) begin
      xfer(1'b0, regs[i], 32'h0);
      chk(40'(rv), 40'h0);
      xfer(1'b1, regs[i], 32'hFFFF_FFA5);
      xfer(1'b0, regs[i], 32'h0);
      chk(40'(rv), 40'(8'hA5 & 8'(`BPC_IMPL_MASK >> (8 * (i % 5)))));
      xfer(1'b1, regs[i], 32'h0);
    end
    xfer(1'b1, 8'hD0, 32'hFF);
    xfer(1'b0, 8'hD0, 32'h0);
    chk(40'({hresp, rv}), 40'h0);
    // Every direction, option, data code on port A, codes 2 and 3 on A0-A4 only
    for (int i = 0; i < 8; i++) begin
      // Codes 2 and 3 keep option set on A0-A4 only, so A4 is the one analog line
      cfg(`BPC_IDX_DATA_A, {8{i[0]}}, (i == 2 || i == 3) ? 8'h1F : {8{i[1]}},
          {8{i[2]}});
      settle(3);
      chk(40'(pull_en[7:0]), (i == 0 || i == 2) ? 40'hFF : 40'h0);
      chk(40'(ana_sel[7:0]), (i == 3) ? 40'h10 : 40'h0);
      chk(40'(pad_oe[7:0]), (i > 3 && i != 5) ? 40'hFF : 40'h0);
      if (i > 5) chk(40'(pad_out[7:0]), 40'({8{i[0]}}));
    end
    // Mixed port: inputs read the pins, outputs the latch
    cfg(`BPC_IDX_DATA_A, 8'h5A, 8'h0F, 8'h0F);
    ext_val <= 40'h30;
    ext_en <= 40'hF0;
    settle(8);
    xfer(1'b0, `BPC_IDX_DATA_A, 32'h0);
    chk(40'(rv), 40'h3A);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, `BPC_IDX_CTRL, 32'(caps[i]));
      settle(3);
      chk(40'({cap2, cap1}), 40'(caps[i][3:2]));
    end
    // Timer outputs replace the latch only while enabled; lines kept as outputs
    ovf_o <= 1'b1;
    xfer(1'b1, `BPC_IDX_CTRL, 32'h3);
    settle(3);
    chk(40'(pad_out[3:2]), 40'h1);
    xfer(1'b1, `BPC_IDX_CTRL, 32'h0);
    settle(3);
    chk(40'(pad_out[3:2]), 40'h2);
    // Serial out open-drain, then push-pull; transmit line busy, then idle
    cfg(`BPC_IDX_DATA_D, 8'h28, 8'h20, 8'h28);
    sout <= 1'b1;
    settle(3);
    chk(40'(pad_oe[27]), 40'h0);
    sout <= 1'b0;
    settle(3);
    chk(40'(pad_oe[27]), 40'h1);
    xfer(1'b1, `BPC_IDX_OPT_D, 32'h28);
    settle(3);
    chk(40'({pad_oe[27], pad_out[27]}), 40'h3);
    tx_act <= 1'b1;
    settle(3);
    chk(40'(pad_out[29]), 40'h0);
    tx_act <= 1'b0;
    settle(3);
    chk(40'(pad_out[29]), 40'h1);
    // Serial and receive inputs follow their pins, then the pull-ups
    ext_en <= 40'h00_16_00_00_F0;
    settle(8);
    chk(40'({rxd, sin, sclk}), 40'h0);
    ext_en <= 40'hF0;
    settle(8);
    chk(40'({rxd, sin, sclk}), 40'h7);
    // Each trigger code on line A4: fall, rise, low level, none
    ext_val <= 40'h10;
    ext_en <= 40'h10;
    cfg(`BPC_IDX_DATA_A, 8'h00, 8'h10, 8'h00);
    for (int t = 0; t < 4; t++) begin
      xfer(1'b1, `BPC_IDX_TRIG, 32'(t));
      settle(8);
      ext_val <= 40'h0;
      cnt_irq(a);
      ext_val <= 40'h10;
      cnt_irq(b);
      if (t == 2) chk(40'(a > 5 && b < a), 40'h1);
      else chk(40'(a * 16 + b), (t == 0) ? 40'h10 : (t == 1) ? 40'h1 : 40'h0);
    end
    test_done;
  end
endmodule
`default_nettype wire
